// ===== verilog/rb_hist_pkg.sv
// Constants shared by the buffer-read command block and its directory source.
// Assumes CDB fields are already parsed by the command front end.
package rb_hist_pkg;

  // Mode codes
  localparam logic [4:0] MODE_ECHO_READ = 5'h0a;
  localparam logic [4:0] MODE_EXP_ECHO  = 5'h1a;
  localparam logic [4:0] MODE_ERR_HIST  = 5'h1c;

  // Error-history buffer identifiers
  localparam logic [7:0] ID_DIR          = 8'h00;
  localparam logic [7:0] ID_DIR_SNAP     = 8'h01;
  localparam logic [7:0] ID_DIR_OWN      = 8'h02;
  localparam logic [7:0] ID_DIR_OWN_SNAP = 8'h03;
  localparam logic [7:0] ID_RSV1_LO      = 8'h04;
  localparam logic [7:0] ID_RSV1_HI      = 8'h0f;
  localparam logic [7:0] ID_HIST_LO      = 8'h10;
  localparam logic [7:0] ID_HIST_HI      = 8'hef;
  localparam logic [7:0] ID_RSV2_LO      = 8'hf0;
  localparam logic [7:0] ID_RSV2_HI      = 8'hfd;
  localparam logic [7:0] ID_CLR_OWN      = 8'hfe;
  localparam logic [7:0] ID_CLR_REL      = 8'hff;

  // Directory layout
  localparam int         DIR_HDR_BYTES   = 32;
  localparam int         DIR_ENTRY_BYTES = 8;
  localparam int         DIR_FIXED_IDS   = 4;
  localparam logic [7:0] DIR_VER_BYTE    = 8'h08;
  localparam logic [7:0] DIR_FLAG_BYTE   = 8'h09;
  localparam logic [7:0] DIR_LEN_MSB     = 8'h1e;
  localparam logic [7:0] DIR_LEN_LSB     = 8'h1f;
  localparam int         FLAG_CLR_SUP    = 0;
  localparam logic [23:0] HIST_OFF_MAX   = 24'h00ffff;

  // Completion status and sense
  localparam logic [7:0] ST_GOOD        = 8'h00;
  localparam logic [7:0] ST_CHECK       = 8'h02;
  localparam logic [3:0] SK_NONE        = 4'h0;
  localparam logic [3:0] SK_ILLEGAL     = 4'h5;
  localparam logic [7:0] ASC_NONE       = 8'h00;
  localparam logic [7:0] ASC_INV_FIELD  = 8'h24;
  localparam logic [7:0] ASCQ_INV_FIELD = 8'h00;
  localparam logic [7:0] ASC_OP_PROG    = 8'h00;
  localparam logic [7:0] ASCQ_OP_PROG   = 8'h16;

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_SEND = 1'b1
  } phase_t;

endpackage

// ===== verilog/hist_dir_rom.sv
// Byte source for the error-history directory, addressed by byte index.
// Assumes directory size stays at most 256 bytes (NUM_HIST up to 24).
`timescale 1ns/1ps
`default_nettype none
module hist_dir_rom
  import rb_hist_pkg::*;
#(
  parameter int          NUM_HIST     = 4,
  parameter logic [23:0] HIST_MAX_LEN = 24'h001000,
  parameter logic [7:0]  VERSION      = 8'h01,
  // Vendor text value is arbitrary
  parameter logic [63:0] VENDOR_ID    = 64'h4142_4344_2020_2020
) (
  // Byte select
  input  wire logic [7:0] idx,
  // Directory byte
  output logic      [7:0] dir_byte
);
  localparam int          N_ENT    = DIR_FIXED_IDS + NUM_HIST;
  localparam logic [15:0] LIST_LEN = 16'(DIR_ENTRY_BYTES * N_ENT);
  localparam logic [31:0] DIR_SIZE = 32'(DIR_HDR_BYTES) + 32'(LIST_LEN);

  logic [7:0]  rel;
  logic [4:0]  ent;
  logic [2:0]  pos;
  logic [31:0] maxlen;
  logic [7:0]  ent_id;

  always_comb begin
    rel      = idx - 8'(DIR_HDR_BYTES);
    ent      = rel[7:3];
    pos      = rel[2:0];
    dir_byte = 8'h00;
    // Fixed ids report the directory itself as their content size
    maxlen   = (ent < 5'(DIR_FIXED_IDS)) ? DIR_SIZE : 32'(HIST_MAX_LEN);
    ent_id   = (ent < 5'(DIR_FIXED_IDS)) ? {3'h0, ent} :
               ID_HIST_LO + 8'(ent) - 8'(DIR_FIXED_IDS);
    if (idx < 8'h08) begin
      dir_byte = VENDOR_ID[8'(63) - {idx[2:0], 3'h0} -: 8];
    end else if (idx == DIR_VER_BYTE) begin
      dir_byte = VERSION;
    end else if (idx == DIR_FLAG_BYTE) begin
      dir_byte = 8'(1) << FLAG_CLR_SUP;
    end else if (idx == DIR_LEN_MSB) begin
      dir_byte = LIST_LEN[15:8]; // [RULE_11]
    end else if (idx == DIR_LEN_LSB) begin
      dir_byte = LIST_LEN[7:0]; // [RULE_11]
    end else if (idx >= 8'(DIR_HDR_BYTES) && 32'(idx) < DIR_SIZE) begin
      // One entry per supported id, list right after header [RULE_12]
      unique case (pos)
        3'd0:    dir_byte = ent_id; // [RULE_13]
        3'd4:    dir_byte = maxlen[31:24]; // [RULE_13]
        3'd5:    dir_byte = maxlen[23:16];
        3'd6:    dir_byte = maxlen[15:8];
        3'd7:    dir_byte = maxlen[7:0];
        default: dir_byte = 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verilog/read_buffer_error_history.sv
// Buffer-read command engine: echo reads and error-history actions.
// Assumes parsed CDB fields, a same-clock data-in sink with ready, and an
// asynchronous-read byte memory for echo and history snapshot content.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RULE_01: Expander mode handled as echo read
// RULE_02: Echo read returns lesser of both lengths; code compares only cmd_alloc[7:0] with the echo length
// RULE_03: Ids 00-03 return directory, offset zero
// RULE_04: Ids 02/03 take history nexus ownership
// RULE_05: History ids stream snapshot from offset
// RULE_06: FE clears owner; FF also releases snapshot
// RULE_07: Foreign nexus with snapshot gets busy
// RULE_08: Bad offset gets invalid field
// RULE_09: Unsupported history id gets invalid field
// RULE_10: Permitted directory actions always return directory
// RULE_11: Directory length field is list size
// RULE_12: One entry per supported id
// RULE_13: Entry: id, zeros, big-endian max length
// RULE_14: History data never exceeds reported maximum
// RULE_15: Reserved ids get invalid field
module read_buffer_error_history
  import rb_hist_pkg::*;
#(
  parameter int          NEXUS_W      = 8,
  parameter int          NUM_HIST     = 4,
  parameter logic [23:0] HIST_MAX_LEN = 24'h001000
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Command
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire logic [4:0]         cmd_mode,
  input  wire logic [7:0]         cmd_buffer_id,
  input  wire logic [23:0]        cmd_offset,
  input  wire logic [23:0]        cmd_alloc,
  input  wire logic [NEXUS_W-1:0] cmd_nexus,
  // Echo buffer write record
  input  wire logic               echo_wr_valid,
  input  wire logic [7:0]         echo_wr_len,
  // Byte memory
  output logic [23:0]             mem_addr,
  output logic                    mem_hist,
  output logic [7:0]              mem_buf,
  input  wire logic [7:0]         mem_data,
  // Data-in stream
  output logic                    din_valid,
  output logic [7:0]              din_data,
  output logic                    din_last,
  input  wire logic               din_ready,
  // Completion
  output logic                    done,
  output logic [7:0]              status,
  output logic [3:0]              sense_key,
  output logic [7:0]              asc,
  output logic [7:0]              ascq,
  // Snapshot and ownership
  output logic                    snap_capture,
  output logic                    snap_release,
  output logic                    snap_valid,
  output logic                    owner_valid
);
  localparam logic [23:0] DIR_SIZE =
    24'(DIR_HDR_BYTES + DIR_ENTRY_BYTES * (DIR_FIXED_IDS + NUM_HIST));
  localparam logic [7:0] HIST_END = ID_HIST_LO + 8'(NUM_HIST);
  // Leading vendor text byte that the directory source sends first
  localparam logic [7:0] DIR_FIRST_BYTE = 8'h41;

  typedef struct packed {
    phase_t               phase;
    logic                 cmd_ready;
    logic                 din_valid;
    logic [7:0]           din_data;
    logic                 din_last;
    logic [23:0]          remain;
    logic [7:0]           idx;
    logic                 from_dir;
    logic [23:0]          mem_addr;
    logic                 mem_hist;
    logic [7:0]           mem_buf;
    logic                 done;
    logic [7:0]           status;
    logic [3:0]           sense_key;
    logic [7:0]           asc;
    logic [7:0]           ascq;
    logic                 owner_valid;
    logic [NEXUS_W-1:0]   owner_id;
    logic                 snap_valid;
    logic                 snap_capture;
    logic                 snap_release;
    logic                 echo_valid;
    logic [7:0]           echo_len;
  } st_t;

  st_t        s;
  st_t        next_s;
  logic [7:0] dir_byte;

  function automatic logic [23:0] min24(input logic [23:0] a,
                                        input logic [23:0] b);
    min24 = (a < b) ? a : b;
  endfunction

  hist_dir_rom #(
    .NUM_HIST     (NUM_HIST),
    .HIST_MAX_LEN (HIST_MAX_LEN)
  ) u_dir (
    .idx      (s.idx),
    .dir_byte (dir_byte)
  );

  // Command classification
  logic accept;
  logic is_hist_mode;
  logic is_echo_mode;
  logic id_dir;
  logic id_hist;
  logic id_hist_ok;
  logic id_rsv;
  logic constrained;
  logic locked;
  logic off_bad;
  logic hist_err;
  logic go;

  assign accept       = cmd_valid && s.cmd_ready;
  assign is_hist_mode = cmd_mode == MODE_ERR_HIST;
  // Expander mode shares the echo path exactly [RULE_01]
  assign is_echo_mode = cmd_mode == MODE_ECHO_READ ||
                        cmd_mode == MODE_EXP_ECHO; // [RULE_01]
  assign id_dir       = cmd_buffer_id <= ID_DIR_OWN_SNAP;
  assign id_hist      = cmd_buffer_id >= ID_HIST_LO &&
                        cmd_buffer_id <= ID_HIST_HI;
  assign id_hist_ok   = id_hist && cmd_buffer_id < HIST_END;
  assign id_rsv       = (cmd_buffer_id >= ID_RSV1_LO &&
                         cmd_buffer_id <= ID_RSV1_HI) ||
                        (cmd_buffer_id >= ID_RSV2_LO &&
                         cmd_buffer_id <= ID_RSV2_HI);
  assign constrained  = cmd_buffer_id != ID_DIR_OWN &&
                        cmd_buffer_id != ID_DIR_OWN_SNAP; // [RULE_04]
  assign locked       = constrained && s.owner_valid &&
                        s.owner_id != cmd_nexus && s.snap_valid; // [RULE_07]
  // Offset must sit inside the snapshot, or be zero for the directory
  assign off_bad      = id_dir ? (cmd_offset != 24'h000000) : // [RULE_03]
                        id_hist_ok && (cmd_offset > HIST_OFF_MAX ||
                        cmd_offset >= HIST_MAX_LEN); // [RULE_08]
  assign hist_err     = locked || id_rsv || (id_hist && !id_hist_ok) ||
                        off_bad;
  assign go           = accept && is_hist_mode && !hist_err;

  always_comb begin
    next_s              = s;
    next_s.done         = 1'b0;
    next_s.snap_capture = 1'b0;
    next_s.snap_release = 1'b0;
    if (echo_wr_valid) begin
      next_s.echo_valid = 1'b1;
      next_s.echo_len   = echo_wr_len;
    end
    unique case (s.phase)
      PH_IDLE: begin
        if (accept) begin
          next_s.status    = ST_GOOD;
          next_s.sense_key = SK_NONE;
          next_s.asc       = ASC_NONE;
          next_s.ascq      = ASC_NONE;
          next_s.idx       = 8'h00;
          next_s.mem_addr  = 24'h000000;
          next_s.mem_hist  = 1'b0;
          next_s.mem_buf   = cmd_buffer_id;
          next_s.from_dir  = 1'b0;
          next_s.remain    = 24'h000000;
          next_s.phase     = PH_SEND;
          if (is_echo_mode && s.echo_valid) begin
            // Upper allocation bytes do not count in echo mode
            next_s.remain = min24({16'h0000, cmd_alloc[7:0]},
                                  {16'h0000, s.echo_len}); // [RULE_02]
          end else if (is_hist_mode && locked) begin
            next_s.phase     = PH_IDLE;
            next_s.done      = 1'b1;
            next_s.status    = ST_CHECK; // [RULE_07]
            next_s.sense_key = SK_ILLEGAL;
            next_s.asc       = ASC_OP_PROG;
            next_s.ascq      = ASCQ_OP_PROG;
          end else if (!is_hist_mode || hist_err) begin
            // Reserved, unsupported, bad offset, unknown mode, or echo read before any echo write
            next_s.phase     = PH_IDLE;
            next_s.done      = 1'b1;
            next_s.status    = ST_CHECK; // [RULE_08] [RULE_09] [RULE_15]
            next_s.sense_key = SK_ILLEGAL;
            next_s.asc       = ASC_INV_FIELD;
            next_s.ascq      = ASCQ_INV_FIELD;
          end else if (id_dir) begin
            next_s.from_dir = 1'b1;
            next_s.remain   = min24(cmd_alloc, DIR_SIZE); // [RULE_10]
            if (cmd_buffer_id[0]) begin
              next_s.snap_capture = 1'b1; // [RULE_03]
              next_s.snap_valid   = 1'b1;
            end
            if (cmd_buffer_id[1]) begin
              next_s.owner_valid = 1'b1; // [RULE_04]
              next_s.owner_id    = cmd_nexus;
            end
          end else if (id_hist_ok) begin
            next_s.mem_hist = 1'b1; // [RULE_05]
            next_s.mem_addr = cmd_offset;
            next_s.remain   = min24(cmd_alloc,
                                    HIST_MAX_LEN - cmd_offset); // [RULE_14]
          end else begin
            next_s.owner_valid = 1'b0; // [RULE_06]
            if (cmd_buffer_id == ID_CLR_REL) begin
              next_s.snap_release = 1'b1; // [RULE_06]
              next_s.snap_valid   = 1'b0;
            end
          end
        end
      end
      PH_SEND: begin
        if (!s.din_valid || din_ready) begin
          if (s.remain != 24'h000000) begin
            next_s.din_valid = 1'b1;
            next_s.din_data  = s.from_dir ? dir_byte : mem_data;
            next_s.din_last  = s.remain == 24'h000001;
            next_s.remain    = s.remain - 24'h000001;
            next_s.idx       = s.idx + 8'h01;
            next_s.mem_addr  = s.mem_addr + 24'h000001;
          end else begin
            next_s.din_valid = 1'b0;
            next_s.din_last  = 1'b0;
            next_s.done      = 1'b1;
            next_s.phase     = PH_IDLE;
          end
        end
      end
    endcase
    next_s.cmd_ready = (next_s.phase == PH_IDLE) && !accept;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cmd_ready    = s.cmd_ready;
  assign mem_addr     = s.mem_addr;
  assign mem_hist     = s.mem_hist;
  assign mem_buf      = s.mem_buf;
  assign din_valid    = s.din_valid;
  assign din_data     = s.din_data;
  assign din_last     = s.din_last;
  assign done         = s.done;
  assign status       = s.status;
  assign sense_key    = s.sense_key;
  assign asc          = s.asc;
  assign ascq         = s.ascq;
  assign snap_capture = s.snap_capture;
  assign snap_release = s.snap_release;
  assign snap_valid   = s.snap_valid;
  assign owner_valid  = s.owner_valid;

  exp_echo_path_a: assert property ( // [RULE_01]
    @(posedge core_clk) disable iff (rst)
    accept && cmd_mode == MODE_EXP_ECHO && s.echo_valid |=>
      s.phase == PH_SEND && !s.from_dir && !s.mem_hist && !s.done)
    else $error("expander mode not handled as echo read");

  echo_len_min_a: assert property ( // [RULE_02]
    @(posedge core_clk) disable iff (rst)
    accept && is_echo_mode && s.echo_valid |=>
      s.remain == min24({16'h0000, $past(cmd_alloc[7:0])},
                        {16'h0000, $past(s.echo_len)}))
    else $error("echo length is not the lesser value");

  dir_offset_a: assert property ( // [RULE_03]
    @(posedge core_clk) disable iff (rst)
    accept && is_hist_mode && id_dir && !locked &&
    cmd_offset != 24'h000000 |=>
      s.done && s.status == ST_CHECK && s.asc == ASC_INV_FIELD)
    else $error("directory with nonzero offset accepted");

  snap_take_a: assert property ( // [RULE_03]
    @(posedge core_clk) disable iff (rst)
    go && id_dir && cmd_buffer_id[0] |=>
      s.snap_capture && s.snap_valid ##1 !s.snap_capture)
    else $error("snapshot not captured");

  owner_take_a: assert property ( // [RULE_04]
    @(posedge core_clk) disable iff (rst)
    go && !constrained |=>
      s.owner_valid && s.owner_id == $past(cmd_nexus))
    else $error("ownership not taken");

  owner_clear_a: assert property ( // [RULE_06]
    @(posedge core_clk) disable iff (rst)
    go && cmd_buffer_id == ID_CLR_REL |=>
      !s.owner_valid && !s.snap_valid && s.snap_release ##1 s.done)
    else $error("clear and release failed");

  foreign_busy_a: assert property ( // [RULE_07]
    @(posedge core_clk) disable iff (rst)
    accept && is_hist_mode && locked |=>
      s.done && s.sense_key == SK_ILLEGAL && s.asc == ASC_OP_PROG &&
      s.ascq == ASCQ_OP_PROG && $stable(s.owner_id))
    else $error("foreign nexus not rejected as busy");

  unsupported_a: assert property ( // [RULE_09]
    @(posedge core_clk) disable iff (rst)
    accept && is_hist_mode && !locked && id_hist && !id_hist_ok |=>
      s.done && s.status == ST_CHECK && s.asc == ASC_INV_FIELD)
    else $error("unsupported history id accepted");

  hist_bound_a: assert property ( // [RULE_14]
    @(posedge core_clk) disable iff (rst)
    s.phase == PH_SEND && s.mem_hist |->
      {1'b0, s.mem_addr} + {1'b0, s.remain} <= {1'b0, HIST_MAX_LEN})
    else $error("history read past reported maximum");

  dir_return_a: assert property ( // [RULE_10]
    @(posedge core_clk) disable iff (rst)
    go && id_dir && cmd_alloc != 24'h000000 |=>
      s.from_dir ##1 s.din_valid && s.din_data == DIR_FIRST_BYTE)
    else $error("directory not returned");
endmodule
`default_nettype wire

// ===== bench/host_model.sv
// Initiator-side model: data-in sink with optional stall, and byte memory.
// Assumes the block's outputs settle well before the next rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and pacing
  input  wire logic        core_clk,
  input  wire logic        stall,
  // Byte memory
  input  wire logic [23:0] mem_addr,
  input  wire logic        mem_hist,
  input  wire logic [7:0]  mem_buf,
  output logic      [7:0]  mem_data,
  // Data-in stream
  input  wire logic        din_valid,
  input  wire logic [7:0]  din_data,
  input  wire logic        din_last,
  output logic             din_ready
);
  logic [8:0] rx[$];
  logic       tog;
  // Content follows address, so a wrong address shows up as wrong data
  assign mem_data = mem_addr[7:0] + mem_buf + {mem_hist, 7'h00};
  initial begin
    tog = 1'b0;
    din_ready = 1'b1;
  end
  always @(posedge core_clk) begin
    if (din_valid === 1'b1 && din_ready === 1'b1)
      rx.push_back({din_last, din_data});
    tog <= #1 ~tog;
    din_ready <= #1 !stall || tog;
  end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the buffer-read command engine.
// Assumes the host model supplies memory bytes and sinks the data-in stream.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rb_hist_pkg::*;
  localparam int          NH  = 2;
  localparam logic [23:0] HML = 24'h000040;
  localparam int DSZ = DIR_HDR_BYTES + DIR_ENTRY_BYTES * (DIR_FIXED_IDS + NH);
  localparam logic [7:0] NA = 8'h0a;
  localparam logic [7:0] NB = 8'h0b;
  logic        core_clk, rst, cmd_valid, cmd_ready, echo_wr_valid, stall;
  logic [4:0]  cmd_mode;
  logic [7:0]  cmd_buffer_id, cmd_nexus, echo_wr_len, mem_buf, mem_data;
  logic [23:0] cmd_offset, cmd_alloc, mem_addr;
  logic [7:0]  din_data, status, asc, ascq;
  logic [3:0]  sense_key;
  logic        mem_hist, din_valid, din_last, din_ready, done;
  logic        snap_capture, snap_release, snap_valid, owner_valid, cap, rel;
  int          fail_count, checks, cyc;

  read_buffer_error_history #(.NUM_HIST(NH), .HIST_MAX_LEN(HML)) uut (
    .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_mode(cmd_mode),
    .cmd_buffer_id(cmd_buffer_id), .cmd_offset(cmd_offset),
    .cmd_alloc(cmd_alloc), .cmd_nexus(cmd_nexus),
    .echo_wr_valid(echo_wr_valid), .echo_wr_len(echo_wr_len),
    .mem_addr(mem_addr), .mem_hist(mem_hist), .mem_buf(mem_buf),
    .mem_data(mem_data), .din_valid(din_valid), .din_data(din_data),
    .din_last(din_last), .din_ready(din_ready), .done(done),
    .status(status), .sense_key(sense_key), .asc(asc), .ascq(ascq),
    .snap_capture(snap_capture), .snap_release(snap_release),
    .snap_valid(snap_valid), .owner_valid(owner_valid));

  host_model u_host (
    .core_clk(core_clk), .stall(stall), .mem_addr(mem_addr),
    .mem_hist(mem_hist), .mem_buf(mem_buf), .mem_data(mem_data),
    .din_valid(din_valid), .din_data(din_data), .din_last(din_last),
    .din_ready(din_ready));

  always #20 core_clk = ~core_clk;

  task automatic print_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard: whole run needs a few hundred cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_st(input logic bad, input logic [7:0] a,
                        input logic [7:0] q);
    chk(status, bad ? ST_CHECK : ST_GOOD);
    chk(sense_key, bad ? SK_ILLEGAL : SK_NONE);
    chk(asc, a);
    chk(ascq, q);
  endtask

  task automatic run_cmd(input logic [4:0] m, input logic [7:0] id,
                         input logic [23:0] off, input logic [23:0] al,
                         input logic [7:0] nx);
    int n;
    u_host.rx.delete();
    cap = 1'b0;
    rel = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge core_clk) #1;
      n++;
    end
    cmd_valid = 1'b1;
    cmd_mode = m;
    cmd_buffer_id = id;
    cmd_offset = off;
    cmd_alloc = al;
    cmd_nexus = nx;
    @(posedge core_clk) #1;
    cmd_valid = 1'b0;
    n = 0;
    do begin
      if (snap_capture === 1'b1) cap = 1'b1;
      if (snap_release === 1'b1) rel = 1'b1;
      if (done === 1'b1) break;
      @(posedge core_clk) #1;
      n++;
    end while (n < 500);
    chk({31'h0, done}, 32'h1);
  endtask

  // Stream of cnt bytes from base, as the host memory holds them
  task automatic chk_data(input logic [23:0] base, input logic [7:0] b,
                          input logic h, input int cnt);
    logic [7:0] e;
    chk(u_host.rx.size(), cnt);
    for (int i = 0; i < cnt && i < u_host.rx.size(); i++) begin
      e = base[7:0] + i[7:0] + b + {h, 7'h00};
      chk({23'h0, u_host.rx[i]}, {23'h0, i == cnt - 1, e});
    end
  endtask

  task automatic t_echo();
    run_cmd(MODE_EXP_ECHO, 8'h00, 24'h0, 24'h10, NA);
    chk_st(1'b1, ASC_INV_FIELD, ASCQ_INV_FIELD);
    echo_wr_len = 8'h06;
    echo_wr_valid = 1'b1;
    @(posedge core_clk) #1;
    echo_wr_valid = 1'b0;
    run_cmd(MODE_EXP_ECHO, 8'h00, 24'h0, 24'h10, NA);
    chk_st(1'b0, ASC_NONE, 8'h00);
    chk_data(24'h0, 8'h00, 1'b0, 6);
    run_cmd(MODE_ECHO_READ, 8'h00, 24'h0, 24'hff0003, NA);
    chk_data(24'h0, 8'h00, 1'b0, 3);
  endtask

  task automatic t_dir();
    logic [7:0]  id;
    logic [63:0] mx;
    int          b;
    stall = 1'b1;
    run_cmd(MODE_ERR_HIST, ID_DIR, 24'h0, 24'd200, NA);
    stall = 1'b0;
    chk_st(1'b0, ASC_NONE, 8'h00);
    chk(u_host.rx.size(), DSZ);
    if (u_host.rx.size() == DSZ) begin
      chk(u_host.rx[9][7:0], 8'h01);
      chk({u_host.rx[30][7:0], u_host.rx[31][7:0]}, DSZ - 32);
      for (int e = 0; e < DIR_FIXED_IDS + NH; e++) begin
        b = 32 + 8 * e;
        id = (e < 4) ? e[7:0] : 8'h10 + e[7:0] - 8'h04;
        // Upper half zero, so entry bytes 1 to 3 are expected as zeros
        mx = (e < 4) ? 64'(DSZ) : {40'h0, HML};
        chk(u_host.rx[b][7:0], id);
        for (int k = 1; k < 8; k++)
          chk(u_host.rx[b + k][7:0], mx[8 * (7 - k) +: 8]);
      end
    end
  endtask

  task automatic t_own();
    run_cmd(MODE_ERR_HIST, ID_DIR_OWN_SNAP, 24'h0, 24'h0, NA);
    chk({cap, owner_valid, snap_valid}, 3'b111);
    run_cmd(MODE_ERR_HIST, ID_DIR, 24'h0, 24'h8, NB);
    chk_st(1'b1, ASC_OP_PROG, ASCQ_OP_PROG);
    chk(u_host.rx.size(), 0);
    run_cmd(MODE_ERR_HIST, ID_DIR_OWN, 24'h0, 24'h4, NB);
    chk_st(1'b0, ASC_NONE, 8'h00);
    chk(u_host.rx.size(), 4);
    run_cmd(MODE_ERR_HIST, ID_DIR_SNAP, 24'h0, 24'h0, NA);
    chk_st(1'b1, ASC_OP_PROG, ASCQ_OP_PROG);
  endtask

  task automatic t_err();
    logic [7:0]  ids[6] = '{8'h05, 8'hf0, 8'h10 + 8'(NH), 8'h00, 8'h10, 8'h11};
    logic [23:0] offs[6] = '{24'h0, 24'h0, 24'h0, 24'h1, HML, 24'h010000};
    for (int i = 0; i < 6; i++) begin
      run_cmd(MODE_ERR_HIST, ids[i], offs[i], 24'h8, NB);
      if (i < 3)
        chk_st(1'b1, ASC_INV_FIELD, ASCQ_INV_FIELD);
      else
        chk_st(1'b1, ASC_INV_FIELD, ASCQ_INV_FIELD);
    end
    run_cmd(5'h02, 8'h00, 24'h0, 24'h8, NB);
    chk_st(1'b1, ASC_INV_FIELD, ASCQ_INV_FIELD);
  endtask

  task automatic t_hist();
    run_cmd(MODE_ERR_HIST, 8'h11, HML - 24'h4, 24'd10, NB);
    chk_st(1'b0, ASC_NONE, 8'h00);
    chk_data(HML - 24'h4, 8'h11, 1'b1, 4);
    stall = 1'b1;
    run_cmd(MODE_ERR_HIST, 8'h10, 24'h0, 24'h3, NB);
    stall = 1'b0;
    chk_data(24'h0, 8'h10, 1'b1, 3);
  endtask

  task automatic t_clear();
    run_cmd(MODE_ERR_HIST, ID_CLR_OWN, 24'h123456, 24'h0, NB);
    chk_st(1'b0, ASC_NONE, 8'h00);
    chk({rel, owner_valid, snap_valid}, 3'b001);
    run_cmd(MODE_ERR_HIST, ID_DIR, 24'h0, 24'h2, NA);
    chk(u_host.rx.size(), 2);
    run_cmd(MODE_ERR_HIST, ID_CLR_REL, 24'hfedcba, 24'h0, NA);
    chk_st(1'b0, ASC_NONE, 8'h00);
    chk({rel, owner_valid, snap_valid}, 3'b100);
  endtask

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_mode = 5'h00;
    cmd_buffer_id = 8'h00;
    cmd_offset = 24'h0;
    cmd_alloc = 24'h0;
    cmd_nexus = 8'h00;
    echo_wr_valid = 1'b0;
    echo_wr_len = 8'h00;
    stall = 1'b0;
    fail_count = 0;
    checks = 0;
    cyc = 0;
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    t_echo();
    t_dir();
    t_own();
    t_err();
    t_hist();
    t_clear();
    print_verdict();
  end
endmodule
`default_nettype wire
